// file: design/plfm_cfg.svh
// Constants of the peer link fault monitor: addresses, fields, codes
`ifndef PLFM_CFG_SVH
`define PLFM_CFG_SVH

// Analog address of the fault status word (2131 decimal)
`define PLFM_STAT_ADDR 16'h0853
// Discrete flag base, flag B sits at base plus B (4095 decimal)
`define PLFM_FLAG_BASE 16'h0FFF
// Width of the fault status word
`define PLFM_STAT_W 16
// Reset value of the fault status word
`define PLFM_STAT_RST 16'h0000
// Bit positions inside the fault status word
`define PLFM_BIT_LOSS1 0
`define PLFM_BIT_LOSS2 1
`define PLFM_BIT_INC1 2
`define PLFM_BIT_INC2 3
`define PLFM_BIT_PERR 4
// Exception codes carried in the answer data
`define PLFM_EXC_FUNC 16'h0001
`define PLFM_EXC_ADDR 16'h0002
// Channel output reset value
`define PLFM_CHAN_RST 16'h0000
// Positions of the pin inputs in the synchroniser vector
`define PLFM_PIN_LINK1 0
`define PLFM_PIN_LINK2 1
`define PLFM_PIN_P2EN 2
`define PLFM_PIN_BUS2 3
`define PLFM_PIN_INC1 4
`define PLFM_PIN_INC2 5
`define PLFM_PIN_PERR 6
`define PLFM_PIN_MB1 7
`define PLFM_PIN_MB2 8
`define PLFM_PIN_N 9

`endif

// file: design/plfm_pkg.sv
// Types of the peer link fault monitor
package plfm_pkg;

    // Port that carries station traffic
    typedef enum logic
    {
        PLFM_PORT_PRIMARY,
        PLFM_PORT_SECONDARY
    } plfm_port_type;

    // Read function codes understood on the request port
    typedef enum logic [7:0]
    {
        PLFM_FN_COILS = 8'h01,
        PLFM_FN_DISC = 8'h02,
        PLFM_FN_HOLD = 8'h03,
        PLFM_FN_INPUT = 8'h04
    } plfm_func_type;

endpackage : plfm_pkg

// file: design/plfm_sync.sv
// Two flop synchroniser bank for pin inputs
`timescale 1ns/100ps
module plfm_sync
#(
    parameter int W = 1
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Asynchronous pins in, synchronised levels out
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] sync_o
);
    import plfm_pkg::*;

    // All state of the bank
    typedef struct packed
    {
        logic [W-1:0] meta; // First stage, read by second only
        logic [W-1:0] sync; // Second stage
    } plfm_sync_type;

    plfm_sync_type r_ff;
    plfm_sync_type nxt_r;

    // Shift pins through both stages
    always_comb
    begin
        nxt_r = r_ff;
        nxt_r.meta = pin_i;
        nxt_r.sync = r_ff.meta;
    end

    // Register the bank; constant reset only
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            r_ff <= '0;
        end
        else
        begin
            r_ff <= nxt_r;
        end
    end

    assign sync_o = r_ff.sync;

endmodule : plfm_sync

// file: design/plfm_monitor.sv
// Peer link fault monitor: failover, fault word, reads, output policy
//
// Operation
// - Primary link lost: move traffic to secondary
// - Switch only if secondary enabled and healthy
// - On failover: indicator red, fault bits set
// - Primary repaired: return, indicator green, bits clear
// - Any data-blocking fault flags and turns red
// - Status word readable on either port
// - Resume station traffic when master goes silent
// - Status word at 2131 for functions 3, 4
// - Bit B at 4095+B for functions 1, 2
// - Faulted channels hold last or drive preset
// - Bit 0: no primary producer communication
// - Bit 1: no secondary producer communication
// - Bit 2: module mismatch on primary
// - Bit 3: module mismatch on secondary
// - Bit 4: producer channel/module/base error
`timescale 1ns/100ps
`include "plfm_cfg.svh"
module plfm_monitor
#(
    parameter int NCH = 4, // Output channels
    parameter int DW = 16 // Channel data width
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Link health pins (asynchronous)
    input wire logic link1_ok_i,
    input wire logic link2_ok_i,
    input wire logic port2_p2p_en_i,
    input wire logic port2_bus_ok_i,
    // Producer fault pins (asynchronous)
    input wire logic incompat1_i,
    input wire logic incompat2_i,
    input wire logic prod_err_i,
    // Outside master talking on each port (asynchronous)
    input wire logic [1:0] master_busy_i,
    // Process data and failure policy (same clock)
    input wire logic [NCH*DW-1:0] chan_data_i,
    input wire logic [NCH-1:0] chan_valid_i,
    input wire logic [NCH-1:0] fail_preset_sel_i,
    input wire logic [NCH*DW-1:0] fail_preset_val_i,
    // Read requests from either port (same clock)
    input wire logic mb_req_i,
    input wire logic [7:0] mb_func_i,
    input wire logic [15:0] mb_addr_i,
    // Read answer
    output logic mb_rsp_valid_o,
    output logic mb_rsp_err_o,
    output logic [15:0] mb_rsp_data_o,
    // Status and control outputs
    output plfm_pkg::plfm_port_type active_port_o,
    output logic led_red_o,
    output logic [1:0] p2p_run_o,
    output logic [`PLFM_STAT_W-1:0] fault_status_o,
    output logic [NCH*DW-1:0] chan_out_o
);
    import plfm_pkg::*;

    // All state of the monitor
    typedef struct packed
    {
        plfm_port_type port; // Port carrying station traffic
        logic led; // Indicator red when set
        logic [1:0] run; // Station traffic allowed per port
        logic [`PLFM_STAT_W-1:0] stat; // Fault status word
        logic rsp_v; // Answer strobe
        logic rsp_e; // Answer is an exception
        logic [15:0] rsp_d; // Answer data
        logic [NCH*DW-1:0] chan; // Channel outputs
    } plfm_mon_type;

    plfm_mon_type r_ff;
    plfm_mon_type nxt_r;
    logic [`PLFM_PIN_N-1:0] pins; // Raw pin vector
    logic [`PLFM_PIN_N-1:0] sy; // Synchronised pins
    logic eligible; // Secondary may take traffic
    logic fault_any; // Process data unusable

    // Is this an analog read of the status word
    function automatic logic is_word(input logic [7:0] f,
                                     input logic [15:0] a);
        is_word = (f == PLFM_FN_HOLD || f == PLFM_FN_INPUT)
                  && a == `PLFM_STAT_ADDR;
    endfunction : is_word

    // Is this a discrete read inside the flag range
    function automatic logic is_flag(input logic [7:0] f,
                                     input logic [15:0] a);
        is_flag = (f == PLFM_FN_COILS || f == PLFM_FN_DISC)
                  && a >= `PLFM_FLAG_BASE
                  && a < `PLFM_FLAG_BASE + 16'(`PLFM_STAT_W);
    endfunction : is_flag

    // Gather the pins; they are outside this clock's domain
    assign pins[`PLFM_PIN_LINK1] = link1_ok_i;
    assign pins[`PLFM_PIN_LINK2] = link2_ok_i;
    assign pins[`PLFM_PIN_P2EN] = port2_p2p_en_i;
    assign pins[`PLFM_PIN_BUS2] = port2_bus_ok_i;
    assign pins[`PLFM_PIN_INC1] = incompat1_i;
    assign pins[`PLFM_PIN_INC2] = incompat2_i;
    assign pins[`PLFM_PIN_PERR] = prod_err_i;
    assign pins[`PLFM_PIN_MB1] = master_busy_i[0];
    assign pins[`PLFM_PIN_MB2] = master_busy_i[1];

    // Two flops on every pin before any decision
    plfm_sync #(.W(`PLFM_PIN_N)) u_sync
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .pin_i(pins),
        .sync_o(sy)
    );

    // Secondary takes over only when configured and its bus is sound
    assign eligible = sy[`PLFM_PIN_P2EN] && sy[`PLFM_PIN_BUS2];

    // Data is unusable if the active link is down or producer faulted
    assign fault_any = r_ff.stat[`PLFM_BIT_PERR]
        | (r_ff.port == PLFM_PORT_PRIMARY
           ? r_ff.stat[`PLFM_BIT_LOSS1] | r_ff.stat[`PLFM_BIT_INC1]
           : r_ff.stat[`PLFM_BIT_LOSS2] | r_ff.stat[`PLFM_BIT_INC2]);

    // Next state of the whole monitor
    always_comb
    begin
        nxt_r = r_ff;
        // Fault bits are plain levels; no read touches them
        nxt_r.stat = `PLFM_STAT_RST;
        nxt_r.stat[`PLFM_BIT_LOSS1] = !sy[`PLFM_PIN_LINK1];
        nxt_r.stat[`PLFM_BIT_LOSS2] = !sy[`PLFM_PIN_LINK2];
        nxt_r.stat[`PLFM_BIT_INC1] = sy[`PLFM_PIN_INC1];
        nxt_r.stat[`PLFM_BIT_INC2] = sy[`PLFM_PIN_INC2];
        nxt_r.stat[`PLFM_BIT_PERR] = sy[`PLFM_PIN_PERR];
        // Port choice: primary unless it is down and secondary is sound
        nxt_r.port = PLFM_PORT_PRIMARY;
        if (!sy[`PLFM_PIN_LINK1] && eligible)
        begin
            nxt_r.port = PLFM_PORT_SECONDARY;
        end
        // Indicator tracks every fault; green once all clear
        nxt_r.led = |nxt_r.stat;
        // Yield the link while a master talks, resume on silence
        nxt_r.run[0] = !sy[`PLFM_PIN_MB1];
        nxt_r.run[1] = !sy[`PLFM_PIN_MB2] && eligible;
        // Read answer one cycle after the request, from any port
        nxt_r.rsp_v = mb_req_i;
        nxt_r.rsp_e = 1'b0;
        nxt_r.rsp_d = 16'h0000;
        if (mb_req_i)
        begin
            if (is_word(mb_func_i, mb_addr_i))
            begin
                nxt_r.rsp_d = r_ff.stat;
            end
            else if (is_flag(mb_func_i, mb_addr_i))
            begin
                // Single flag in bit 0 of the answer
                nxt_r.rsp_d[0] = r_ff.stat[4'(mb_addr_i
                                 - `PLFM_FLAG_BASE)];
            end
            else
            begin
                // Known read at a foreign address, else unknown function
                nxt_r.rsp_e = 1'b1;
                nxt_r.rsp_d = (mb_func_i >= PLFM_FN_COILS
                               && mb_func_i <= PLFM_FN_INPUT)
                              ? `PLFM_EXC_ADDR : `PLFM_EXC_FUNC;
            end
        end
        // Channels: live data when sound, else policy per channel
        for (int i = 0; i < NCH; i++)
        begin
            if (!fault_any)
            begin
                if (chan_valid_i[i])
                begin
                    nxt_r.chan[i*DW +: DW] = chan_data_i[i*DW +: DW];
                end
            end
            else if (fail_preset_sel_i[i])
            begin
                nxt_r.chan[i*DW +: DW] =
                    fail_preset_val_i[i*DW +: DW];
            end
            // Hold-last leaves the channel untouched
        end
    end

    // Register the whole monitor
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            r_ff.port <= PLFM_PORT_PRIMARY;
            r_ff.led <= 1'b0;
            r_ff.run <= 2'h3;
            r_ff.stat <= `PLFM_STAT_RST;
            r_ff.rsp_v <= 1'b0;
            r_ff.rsp_e <= 1'b0;
            r_ff.rsp_d <= 16'h0000;
            r_ff.chan <= {NCH{DW'(`PLFM_CHAN_RST)}};
        end
        else
        begin
            r_ff <= nxt_r;
        end
    end

    // Outputs straight from flops
    assign mb_rsp_valid_o = r_ff.rsp_v;
    assign mb_rsp_err_o = r_ff.rsp_e;
    assign mb_rsp_data_o = r_ff.rsp_d;
    assign active_port_o = r_ff.port;
    assign led_red_o = r_ff.led;
    assign p2p_run_o = r_ff.run;
    assign fault_status_o = r_ff.stat;
    assign chan_out_o = r_ff.chan;

    property p_failover;
        @(posedge clk_i) disable iff (!rst_n_i)
        !sy[`PLFM_PIN_LINK1] && eligible
        |=> active_port_o == PLFM_PORT_SECONDARY ##0 led_red_o;
    endproperty
    a_failover: assert property (p_failover)
        else $error("no failover to secondary");

    property p_no_switch;
        @(posedge clk_i) disable iff (!rst_n_i)
        !eligible |=> active_port_o == PLFM_PORT_PRIMARY;
    endproperty
    a_no_switch: assert property (p_no_switch)
        else $error("switched to ineligible secondary");

    property p_return;
        @(posedge clk_i) disable iff (!rst_n_i)
        sy[`PLFM_PIN_LINK1] && !sy[`PLFM_PIN_INC1] && !sy[`PLFM_PIN_PERR]
        && sy[`PLFM_PIN_LINK2] && !sy[`PLFM_PIN_INC2]
        |=> active_port_o == PLFM_PORT_PRIMARY && !led_red_o;
    endproperty
    a_return: assert property (p_return)
        else $error("no return to primary with green");

    property p_red;
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(fault_status_o != 16'h0000) |-> led_red_o;
    endproperty
    a_red: assert property (p_red)
        else $error("fault without red indicator");

    property p_bit0;
        @(posedge clk_i) disable iff (!rst_n_i)
        $fell(link1_ok_i) ##1 !link1_ok_i[*2]
        |=> fault_status_o[`PLFM_BIT_LOSS1];
    endproperty
    a_bit0: assert property (p_bit0)
        else $error("primary loss bit not set in 3 cycles");

    property p_word;
        @(posedge clk_i) disable iff (!rst_n_i)
        mb_req_i && is_word(mb_func_i, mb_addr_i)
        |=> mb_rsp_valid_o && !mb_rsp_err_o
            && mb_rsp_data_o == $past(fault_status_o);
    endproperty
    a_word: assert property (p_word)
        else $error("status word answer wrong");

    property p_flag;
        @(posedge clk_i) disable iff (!rst_n_i)
        mb_req_i && is_flag(mb_func_i, mb_addr_i)
        |=> mb_rsp_data_o[0] == $past(fault_status_o[4'(mb_addr_i
            - `PLFM_FLAG_BASE)]) && mb_rsp_data_o[15:1] == 15'h0000;
    endproperty
    a_flag: assert property (p_flag)
        else $error("flag answer wrong");

    property p_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        fault_any && !fail_preset_sel_i[NCH-1]
        |=> $stable(chan_out_o[NCH*DW-1 -: DW]);
    endproperty
    a_hold: assert property (p_hold)
        else $error("held channel changed under fault");

    property p_resume;
        @(posedge clk_i) disable iff (!rst_n_i)
        $fell(master_busy_i[0]) ##1 !master_busy_i[0][*2]
        |=> p2p_run_o[0];
    endproperty
    a_resume: assert property (p_resume)
        else $error("station traffic not resumed");

endmodule : plfm_monitor

// file: test/plfm_peer_model.sv
// Producer station and outside master model for the fault monitor bench
`timescale 1ns/100ps
module plfm_peer_model
(
    // Bench clock
    input wire logic clk_i,
    // Scenario commands from the bench
    input wire logic [6:0] cond_i,
    input wire logic [1:0] seize_i,
    input wire logic [3:0] send_i,
    input wire logic [63:0] data_i,
    // Pins toward the monitor
    output logic [6:0] pins_o,
    output logic [1:0] busy_o,
    output logic [63:0] chan_data_o,
    output logic [3:0] chan_valid_o
);
    // Pins move on the falling edge, well clear of the sampling edge
    always @(negedge clk_i)
    begin
        pins_o <= cond_i;
        // Outside master seizes a port on command
        busy_o <= seize_i;
        chan_valid_o <= send_i;
        // Data outside a valid beat keeps toggling, never a stale copy
        if (|send_i)
            chan_data_o <= data_i;
        else
            chan_data_o <= ~chan_data_o;
    end
endmodule : plfm_peer_model

// file: test/peer_link_fault_monitor_tb_top.sv
// Self-checking bench of the peer link fault monitor
`timescale 1ns/100ps
module peer_link_fault_monitor_tb_top;
    import plfm_pkg::*;

    // One row: pin condition, expected fault bits, expected port
    typedef struct packed
    {
        logic [6:0] cond;
        logic [4:0] st;
        logic port;
    } plfm_row_type;

    logic clk_i;
    logic rst_n_i;
    // Bench to model commands
    logic [6:0] cond;
    logic [1:0] seize;
    logic [3:0] send;
    logic [63:0] sdata;
    // Model to monitor pins
    logic [6:0] pins;
    logic [1:0] busy;
    logic [63:0] cdata;
    logic [3:0] cvalid;
    // Request side and policy
    logic [3:0] psel;
    logic [63:0] pval;
    logic mb_req;
    logic [7:0] mb_func;
    logic [15:0] mb_addr;
    // Monitor outputs
    logic rsp_valid;
    logic rsp_err;
    logic [15:0] rsp_data;
    plfm_port_type port;
    logic led;
    logic [1:0] run;
    logic [15:0] stat;
    logic [63:0] chan;
    // Scoreboard
    int mismatches;
    int cmp_count;
    plfm_row_type rows [0:8];
    logic e;
    logic [15:0] d;

    plfm_peer_model peer_u
    (
        .clk_i(clk_i), .cond_i(cond), .seize_i(seize), .send_i(send),
        .data_i(sdata), .pins_o(pins), .busy_o(busy),
        .chan_data_o(cdata), .chan_valid_o(cvalid)
    );

    plfm_monitor dut_u
    (
        .clk_i(clk_i), .rst_n_i(rst_n_i),
        .link1_ok_i(pins[0]), .link2_ok_i(pins[1]),
        .port2_p2p_en_i(pins[2]), .port2_bus_ok_i(pins[3]),
        .incompat1_i(pins[4]), .incompat2_i(pins[5]),
        .prod_err_i(pins[6]), .master_busy_i(busy),
        .chan_data_i(cdata), .chan_valid_i(cvalid),
        .fail_preset_sel_i(psel), .fail_preset_val_i(pval),
        .mb_req_i(mb_req), .mb_func_i(mb_func), .mb_addr_i(mb_addr),
        .mb_rsp_valid_o(rsp_valid), .mb_rsp_err_o(rsp_err),
        .mb_rsp_data_o(rsp_data), .active_port_o(port),
        .led_red_o(led), .p2p_run_o(run), .fault_status_o(stat),
        .chan_out_o(chan)
    );

    // Free running 20 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // Verdict, reached from the main flow or a hung wait
    task end_of_test;
        if (mismatches == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test

    // Four-state compare of one 16-bit result
    task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One read request; answer is caught within a bounded wait
    task rd(input logic [7:0] f, input logic [15:0] a,
            output logic ex, output logic [15:0] dat);
        int n;
        @(negedge clk_i);
        mb_func = f;
        mb_addr = a;
        mb_req = 1'b1;
        @(negedge clk_i);
        mb_req = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 3)
        begin
            @(negedge clk_i);
            n++;
        end
        if (n == 3)
        begin
            mismatches++;
            $display("[FAIL] answer strobe expected 1 seen 0");
            end_of_test();
        end
        ex = rsp_err;
        dat = rsp_data;
    endtask : rd

    // Main sequence
    initial
    begin
        rst_n_i = 1'b0;
        cond = 7'h0F;
        seize = 2'h0;
        send = 4'h0;
        sdata = 64'h0000_0000_0000_0000;
        psel = 4'h1;
        pval = 64'h0000_0000_0000_A5A5;
        mb_req = 1'b0;
        mb_func = 8'h00;
        mb_addr = 16'h0000;
        mismatches = 0;
        cmp_count = 0;
        // Bits {perr,inc2,inc1,bus2,p2en,link2,link1}
        rows = '{'{7'h0F, 5'h00, 1'b0}, '{7'h0E, 5'h01, 1'b1},
                 '{7'h0A, 5'h01, 1'b0}, '{7'h06, 5'h01, 1'b0},
                 '{7'h0D, 5'h02, 1'b0}, '{7'h1F, 5'h04, 1'b0},
                 '{7'h2F, 5'h08, 1'b0}, '{7'h4F, 5'h10, 1'b0},
                 '{7'h0F, 5'h00, 1'b0}};
        repeat (12) @(negedge clk_i);
        chk("reset word", 16'h0000, stat);
        chk("reset ctl", 16'h0000, {12'h000, port, led, rsp_valid, chan[0]});
        rst_n_i = 1'b1;
        repeat (5) @(negedge clk_i);
        // Condition table, read back through every read function
        for (int i = 0; i < 9; i++)
        begin
            cond <= rows[i].cond;
            repeat (5) @(negedge clk_i);
            chk("status", 16'(rows[i].st), stat);
            chk("port", 16'(rows[i].port), 16'(port));
            chk("led", 16'(|rows[i].st), 16'(led));
            rd(8'h03, 16'h0853, e, d);
            chk("hold read", 16'(rows[i].st), {e, d[14:0]});
            rd(8'h04, 16'h0853, e, d);
            chk("input rd", 16'(rows[i].st), {e, d[14:0]});
            for (int b = 0; b < 5; b++)
            begin
                rd(b[0] ? 8'h01 : 8'h02, 16'h0FFF + 16'(b), e, d);
                chk("flag", 16'(rows[i].st[b]), {e, d[14:0]});
            end
        end
        // Refused reads: unknown function, wrong word, flag past bit 15
        rd(8'h05, 16'h0853, e, d);
        chk("func exc", 16'h8001, {e, d[14:0]});
        // Answer stands for one cycle only, then all zero
        @(negedge clk_i);
        chk("strobe", 16'h0000, {14'h0000, rsp_valid, rsp_err});
        chk("idle data", 16'h0000, rsp_data);
        rd(8'h03, 16'h0854, e, d);
        chk("addr exc", 16'h8002, {e, d[14:0]});
        rd(8'h01, 16'h100F, e, d);
        chk("flag exc", 16'h8002, {e, d[14:0]});
        // Healthy data passes, then preset on ch0 and hold on ch1
        sdata <= 64'h4444_3333_2222_1111;
        send <= 4'hF;
        @(negedge clk_i);
        send <= 4'h0;
        repeat (3) @(negedge clk_i);
        chk("chan0", 16'h1111, chan[15:0]);
        chk("chan1", 16'h2222, chan[31:16]);
        cond <= 7'h4F;
        repeat (5) @(negedge clk_i);
        sdata <= 64'h8888_7777_6666_5555;
        send <= 4'hF;
        @(negedge clk_i);
        send <= 4'h0;
        repeat (3) @(negedge clk_i);
        chk("chan0 preset", 16'hA5A5, chan[15:0]);
        chk("chan1 hold", 16'h2222, chan[31:16]);
        chk("chan3 hold", 16'h4444, chan[63:48]);
        cond <= 7'h0F;
        // Outside master takes the primary link, then goes quiet
        seize <= 2'h1;
        repeat (6) @(negedge clk_i);
        chk("run seized", 16'h0002, 16'(run));
        seize <= 2'h0;
        repeat (6) @(negedge clk_i);
        chk("run resumed", 16'h0003, 16'(run));
        end_of_test();
    end
endmodule : peer_link_fault_monitor_tb_top
